// ===== core/mto_accum.sv
// Thermal accumulator of one motor channel.
`timescale 1ns/1ps
module mto_accum
  import mto_pkg::*;
#(
  parameter int ACC_WIDTH = ACC_W,
  parameter int CUR_WIDTH = CUR_W,
  parameter int SHIFT     = ACC_SHIFT
) (
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_resetn,
  input  wire logic                 i_clear,
  input  wire logic                 i_tick,
  input  wire logic                 i_enable,
  input  wire logic                 i_use_current,
  input  wire logic [CUR_WIDTH-1:0] i_current,
  input  wire logic [CUR_WIDTH-1:0] i_rated,
  output logic      [ACC_WIDTH-1:0] o_acc,
  output logic                      o_pre,
  output logic                      o_full
);
  // ==========================================================================
  // Leaky integration; the steady state equals the current shifted up.
  logic [ACC_WIDTH:0]   sum;
  logic [ACC_WIDTH-1:0] cur_in;
  logic [ACC_WIDTH-1:0] thr;

  always_comb begin
    cur_in = i_use_current ? ACC_WIDTH'(i_current) : '0;
    sum    = {1'b0, o_acc} + {1'b0, cur_in} - {1'b0, (o_acc >> SHIFT)};
    thr    = ACC_WIDTH'(i_rated) << SHIFT;
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_acc <= '0;
    end else if (i_clear || !i_enable) begin
      o_acc <= '0;
    end else if (i_tick) begin
      o_acc <= sum[ACC_WIDTH] ? '1 : sum[ACC_WIDTH-1:0];
    end
  end

  // Threshold flags are registered so the wide multiply stays off the trip path.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pre  <= 1'b0;
      o_full <= 1'b0;
    end else if (i_clear || !i_enable) begin
      o_pre  <= 1'b0;
      o_full <= 1'b0;
    end else begin
      o_pre  <= pct_reached(32'(o_acc), 32'(thr), PRE_PCT);
      o_full <= pct_reached(32'(o_acc), 32'(thr), FULL_PCT);
    end
  end

  // ==========================================================================
  // Checks
  disabled_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !i_enable |=> (o_acc == '0) ##1 (!o_pre && !o_full))
    else $error("disabled channel kept heat or flags");
  reset_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_clear |=> o_acc == '0)
    else $error("reset input did not clear accumulator");
  cooling_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_tick && i_enable && !i_clear && !i_use_current && (o_acc >> SHIFT) != '0) |=> o_acc < $past(o_acc))
    else $error("idle channel did not cool");
  heating_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_tick && i_enable && !i_clear && i_use_current && !(&o_acc)
     && ACC_WIDTH'(i_current) > (o_acc >> SHIFT)) |=> o_acc > $past(o_acc))
    else $error("selected channel did not heat");
endmodule

// ===== core/mto_monitor.sv
// Top of the motor thermal overload monitor with its register port.
//
// Summary of operation
// - Selected enabled channel integrates measured current.
// - Unselected enabled channel integrates zero, cools.
// - Disabled channel: no integration, alarm, trip.
// - Prealarm output and display at 85 percent.
// - At 100 percent stop output, record trip.
// - Prealarm alone never trips the drive.
// - Prealarm on terminal coded 8 or 108.
// - External relay input trips, external fault code.
// - External relay taken from terminal coded 7.
// - Second select also enables other second functions.
// - Second select uses second rated-current setting.
// - Reset or reset input clears accumulated heat.
// - Second setting 9999 means second channel invalid.
// - First setting zero disables protection while the first set is in use.
`timescale 1ns/1ps
module mto_monitor
  import mto_pkg::*;
#(
  parameter int P_TICK_CYCLES = TICK_CYCLES
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_resetn,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [31:0]       i_wr_data,
  input  wire logic              i_wr_en,
  input  wire logic              i_rd_en,
  output logic      [31:0]       o_rd_data,
  input  wire logic [CUR_W-1:0]  i_output_current,
  input  wire logic [N_IN-1:0]   i_in_term,
  input  wire logic              i_fault_reset,
  input  wire logic              i_transistor_overload,
  output logic      [N_OUT-1:0]  o_out_term,
  output logic                   o_prealarm_display,
  output logic                   o_output_stop,
  output logic                   o_motor_overload_trip,
  output logic                   o_external_relay_trip,
  output logic                   o_transistor_overload_trip,
  output logic      [7:0]        o_fault_code,
  output logic                   o_second_set_active,
  output logic                   o_irq
);
  // ==========================================================================
  // Settings registers
  logic [CUR_W-1:0]        rated1_reg;
  logic [CUR_W-1:0]        rated2_reg;
  logic [CUR_W-1:0]        mtype2_reg;
  logic [N_IN*SEL_W-1:0]   insel_reg;
  logic [N_OUT*SEL_W-1:0]  outsel_reg;
  logic [IRQ_W-1:0]        irq_stat_reg;
  logic [IRQ_W-1:0]        irq_en_reg;
  logic [IRQ_W-1:0]        irq_stat_next;
  logic [IRQ_W-1:0]        irq_set;
  logic [IRQ_W-1:0]        irq_clr;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rated1_reg <= RATED1_RST;
      rated2_reg <= RATED2_RST;
      mtype2_reg <= MTYPE2_RST;
      insel_reg  <= {N_IN{SEL_RST}};
      outsel_reg <= {N_OUT{SEL_RST}};
      irq_en_reg <= '0;
    end else if (i_wr_en) begin
      if (i_addr == OFS_RATED1) begin
        rated1_reg <= i_wr_data[CUR_W-1:0];
      end else if (i_addr == OFS_RATED2) begin
        rated2_reg <= i_wr_data[CUR_W-1:0];
      end else if (i_addr == OFS_MTYPE2) begin
        mtype2_reg <= i_wr_data[CUR_W-1:0];
      end else if (i_addr == OFS_INSEL_LO) begin
        insel_reg[4*SEL_W-1:0] <= i_wr_data;
      end else if (i_addr == OFS_INSEL_HI) begin
        insel_reg[N_IN*SEL_W-1:4*SEL_W] <= i_wr_data[(N_IN-4)*SEL_W-1:0];
      end else if (i_addr == OFS_OUTSEL) begin
        outsel_reg <= i_wr_data[N_OUT*SEL_W-1:0];
      end else if (i_addr == OFS_IRQ_EN) begin
        irq_en_reg <= i_wr_data[IRQ_W-1:0];
      end
    end
  end

  // ==========================================================================
  // Integration tick
  logic [31:0] tick_cnt_reg;
  logic        tick_reg;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg >= 32'(P_TICK_CYCLES - 1)) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      tick_reg     <= 1'b0;
    end
  end

  // ==========================================================================
  // Channel selection
  logic rt_term;
  logic ext_term;
  logic rt_eff;
  logic en1;
  logic en2;
  logic use1;
  logic use2;

  always_comb begin
    rt_term  = term_any(insel_reg, i_in_term, SEL_RT);
    ext_term = term_any(insel_reg, i_in_term, SEL_EXT);
    rt_eff   = o_second_set_active && (rated2_reg != RATED_INVALID);
    en1      = (rated1_reg != '0) && (rated1_reg <= RATED_MAX);
    en2      = (rated2_reg != '0) && (rated2_reg <= RATED_MAX);
    use1     = !rt_eff;
    use2     = rt_eff;
  end

  // The select flag is exported so the rest of the drive switches its second set too.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_second_set_active <= 1'b0;
    end else begin
      o_second_set_active <= rt_term;
    end
  end

  // ==========================================================================
  // Accumulators
  logic [ACC_W-1:0] acc1;
  logic [ACC_W-1:0] acc2;
  logic             pre1;
  logic             pre2;
  logic             full1;
  logic             full2;
  logic             sel_pre;
  logic             sel_full;

  mto_accum u_ch1 (
    .i_sys_clk     (i_sys_clk),
    .i_resetn      (i_resetn),
    .i_clear       (i_fault_reset),
    .i_tick        (tick_reg),
    .i_enable      (en1),
    .i_use_current (use1),
    .i_current     (i_output_current),
    .i_rated       (rated1_reg),
    .o_acc         (acc1),
    .o_pre         (pre1),
    .o_full        (full1)
  );

  mto_accum u_ch2 (
    .i_sys_clk     (i_sys_clk),
    .i_resetn      (i_resetn),
    .i_clear       (i_fault_reset),
    .i_tick        (tick_reg),
    .i_enable      (en2),
    .i_use_current (use2),
    .i_current     (i_output_current),
    .i_rated       (rated2_reg),
    .o_acc         (acc2),
    .o_pre         (pre2),
    .o_full        (full2)
  );

  always_comb begin
    sel_pre  = rt_eff ? pre2 : pre1;
    sel_full = rt_eff ? full2 : full1;
  end

  // ==========================================================================
  // Prealarm and output terminals
  // The prealarm only informs; it feeds no trip term below.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_prealarm_display <= 1'b0;
    end else begin
      o_prealarm_display <= sel_pre;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_out_term <= '0;
    end else begin
      for (int j = 0; j < N_OUT; j++) begin
        if (outsel_reg[j*SEL_W +: SEL_W] == SEL_PRE_POS) begin
          o_out_term[j] <= sel_pre;
        end else if (outsel_reg[j*SEL_W +: SEL_W] == SEL_PRE_NEG) begin
          o_out_term[j] <= !sel_pre;
        end else begin
          o_out_term[j] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // Trip latch; the first fault code is kept so the root cause is not overwritten.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_output_stop              <= 1'b0;
      o_motor_overload_trip      <= 1'b0;
      o_external_relay_trip      <= 1'b0;
      o_transistor_overload_trip <= 1'b0;
      o_fault_code               <= FAULT_NONE;
    end else if (i_fault_reset) begin
      o_output_stop              <= 1'b0;
      o_motor_overload_trip      <= 1'b0;
      o_external_relay_trip      <= 1'b0;
      o_transistor_overload_trip <= 1'b0;
      o_fault_code               <= FAULT_NONE;
    end else begin
      if (ext_term) begin
        o_external_relay_trip <= 1'b1;
      end
      if (i_transistor_overload) begin
        o_transistor_overload_trip <= 1'b1;
      end
      if (sel_full) begin
        o_motor_overload_trip <= 1'b1;
      end
      if (ext_term || i_transistor_overload || sel_full) begin
        o_output_stop <= 1'b1;
      end
      if (!o_output_stop) begin
        if (ext_term) begin
          o_fault_code <= FAULT_OHT;
        end else if (i_transistor_overload) begin
          o_fault_code <= FAULT_THT;
        end else if (sel_full) begin
          o_fault_code <= FAULT_THM;
        end
      end
    end
  end

  // ==========================================================================
  // Interrupts; a new event beats a clear in the same cycle.
  always_comb begin
    irq_set                = '0;
    irq_set[IRQ_PRE]       = sel_pre && !o_prealarm_display;
    irq_set[IRQ_THM]       = sel_full && !o_motor_overload_trip && !i_fault_reset;
    irq_set[IRQ_OHT]       = ext_term && !o_external_relay_trip && !i_fault_reset;
    irq_set[IRQ_THT]       = i_transistor_overload && !o_transistor_overload_trip && !i_fault_reset;
    irq_clr                = (i_wr_en && i_addr == OFS_IRQ_CLR) ? i_wr_data[IRQ_W-1:0] : '0;
    irq_stat_next          = (irq_stat_reg & ~irq_clr) | irq_set;
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_stat_reg <= '0;
      o_irq        <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      o_irq        <= |(irq_stat_next & irq_en_reg);
    end
  end

  // ==========================================================================
  // Read port; data follow one cycle after read enable and clear when it drops.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rd_data <= '0;
    end else if (!i_rd_en) begin
      o_rd_data <= '0;
    end else if (i_addr == OFS_RATED1) begin
      o_rd_data <= 32'(rated1_reg);
    end else if (i_addr == OFS_RATED2) begin
      o_rd_data <= 32'(rated2_reg);
    end else if (i_addr == OFS_MTYPE2) begin
      o_rd_data <= 32'(mtype2_reg);
    end else if (i_addr == OFS_INSEL_LO) begin
      o_rd_data <= insel_reg[4*SEL_W-1:0];
    end else if (i_addr == OFS_INSEL_HI) begin
      o_rd_data <= 32'(insel_reg[N_IN*SEL_W-1:4*SEL_W]);
    end else if (i_addr == OFS_OUTSEL) begin
      o_rd_data <= 32'(outsel_reg);
    end else if (i_addr == OFS_STATUS) begin
      o_rd_data <= {16'h0000, o_fault_code, 1'b0, rt_eff, o_prealarm_display, o_output_stop,
                    o_transistor_overload_trip, o_external_relay_trip, o_motor_overload_trip, o_second_set_active};
    end else if (i_addr == OFS_ACC1) begin
      o_rd_data <= 32'(acc1);
    end else if (i_addr == OFS_ACC2) begin
      o_rd_data <= 32'(acc2);
    end else if (i_addr == OFS_IRQ_STAT) begin
      o_rd_data <= 32'(irq_stat_reg);
    end else if (i_addr == OFS_IRQ_EN) begin
      o_rd_data <= 32'(irq_en_reg);
    end else begin
      o_rd_data <= '0;
    end
  end

  // ==========================================================================
  // Checks
  prealarm_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    sel_pre |=> o_prealarm_display)
    else $error("prealarm missed at 85 percent");
  prealarm_drop_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (!sel_pre ##1 !sel_pre) |-> !o_prealarm_display)
    else $error("prealarm stayed below 85 percent");
  prealarm_notrip_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (!o_output_stop && sel_pre && !sel_full && !ext_term && !i_transistor_overload) |=> !o_output_stop)
    else $error("prealarm alone tripped");
  term_polarity_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_out_term[0] |-> ($past(outsel_reg[SEL_W-1:0]) == SEL_PRE_POS && o_prealarm_display)
                      || $past(outsel_reg[SEL_W-1:0]) == SEL_PRE_NEG)
    else $error("terminal driven without prealarm code");
  motor_trip_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (sel_full && !i_fault_reset) |=> o_output_stop && o_motor_overload_trip)
    else $error("no trip at 100 percent");
  ext_trip_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (ext_term && !i_fault_reset && !o_output_stop) |=> o_output_stop && o_fault_code == FAULT_OHT)
    else $error("external relay did not trip");
  ext_source_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    $rose(o_external_relay_trip) |-> $past(ext_term))
    else $error("external trip without coded terminal");
  trip_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (o_output_stop && !i_fault_reset) |=> o_output_stop && $stable(o_fault_code))
    else $error("trip state not held");
  second_sel_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (rt_eff && tick_reg) |=> acc1 <= $past(acc1))
    else $error("first channel heated while second selected");
  invalid_ch_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (rated2_reg == RATED_INVALID) |-> !en2 && !rt_eff)
    else $error("invalid second channel active");
  first_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (rated1_reg == '0 && $past(rated1_reg) == '0 && !rt_eff) |=> !o_prealarm_display)
    else $error("zero setting still alarms");
  cover_pre_c: cover property (@(posedge i_sys_clk) $rose(o_prealarm_display));
  cover_thm_c: cover property (@(posedge i_sys_clk) $rose(o_motor_overload_trip));
  cover_oht_c: cover property (@(posedge i_sys_clk) $rose(o_external_relay_trip));
  cover_rt_c: cover property (@(posedge i_sys_clk) $rose(o_second_set_active) && en2);
endmodule

// ===== core/mto_pkg.sv
// Shared constants, register map and helpers of the motor thermal overload monitor.
package mto_pkg;
  // ==========================================================================
  // Widths and terminal counts
  localparam int CUR_W     = 16;
  localparam int ACC_W     = 28;
  localparam int ACC_SHIFT = 8;
  localparam int N_IN      = 7;
  localparam int N_OUT     = 3;
  localparam int SEL_W     = 8;
  localparam int ADDR_W    = 8;
  localparam int IRQ_W     = 4;
  // ==========================================================================
  // Rated-current settings, unit 0.1 A
  localparam logic [CUR_W-1:0] RATED_INVALID = 16'h270f;
  localparam logic [CUR_W-1:0] RATED_MAX     = 16'h1388;
  localparam logic [CUR_W-1:0] RATED1_RST    = 16'h0000;
  localparam logic [CUR_W-1:0] RATED2_RST    = 16'h270f;
  localparam logic [CUR_W-1:0] MTYPE2_RST    = 16'h270f;
  localparam int               PRE_PCT       = 85;
  localparam int               FULL_PCT      = 100;
  // ==========================================================================
  // Terminal function codes
  localparam logic [SEL_W-1:0] SEL_RT      = 8'h03;
  localparam logic [SEL_W-1:0] SEL_EXT     = 8'h07;
  localparam logic [SEL_W-1:0] SEL_PRE_POS = 8'h08;
  localparam logic [SEL_W-1:0] SEL_PRE_NEG = 8'h6c;
  localparam logic [SEL_W-1:0] SEL_RST     = 8'hff;
  // ==========================================================================
  // Integration tick
  localparam int TICK_TIME_US = 1000;
  localparam int CLK_MHZ      = 125;
  localparam int TICK_CYCLES  = TICK_TIME_US * CLK_MHZ;
  // ==========================================================================
  // Fault codes, values are arbitrary
  localparam logic [7:0] FAULT_NONE = 8'h00;
  localparam logic [7:0] FAULT_THM  = 8'h01;
  localparam logic [7:0] FAULT_THT  = 8'h02;
  localparam logic [7:0] FAULT_OHT  = 8'h03;
  // ==========================================================================
  // Interrupt bits
  localparam int IRQ_PRE = 0;
  localparam int IRQ_THM = 1;
  localparam int IRQ_OHT = 2;
  localparam int IRQ_THT = 3;
  // ==========================================================================
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_RATED1   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RATED2   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MTYPE2   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_INSEL_LO = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_INSEL_HI = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_OUTSEL   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_ACC1     = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_ACC2     = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR  = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 8'h2c;
  // ==========================================================================
  // Helpers
  function automatic logic pct_reached(input logic [31:0] acc, input logic [31:0] thr, input int pct);
    return ({8'h00, acc} * 40'd100) >= ({8'h00, thr} * 40'(pct));
  endfunction

  function automatic logic term_any(input logic [N_IN*SEL_W-1:0] sel, input logic [N_IN-1:0] t,
                                    input logic [SEL_W-1:0] code);
    logic r;
    r = 1'b0;
    for (int i = 0; i < N_IN; i++) begin
      r = r | (t[i] & (sel[i*SEL_W +: SEL_W] == code));
    end
    return r;
  endfunction
endpackage

// ===== tb/motor_thermal_overload_monitor_tb.sv
// Self-checking testbench of the motor thermal overload monitor.
`timescale 1ns/1ps
module motor_thermal_overload_monitor_tb;
  import mto_pkg::*;
  localparam int TK = 4;
  logic              clk, rstn, wen, ren, frst, tov, heat, cont;
  logic [ADDR_W-1:0] addr;
  logic [31:0]       wd, rdd, v, a1;
  logic [CUR_W-1:0]  cur;
  logic [N_IN-1:1]   th;
  logic [N_OUT-1:0]  ot;
  logic              pre, stop, mtr, ext, ttr, sec, irq;
  logic [7:0]        fc;
  int                errors, checked, seed;
  // ==========================================================================
  // Clock and instances
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  mto_relay_model mto_relay_model_inst (.i_sys_clk(clk), .i_resetn(rstn), .i_overheat(heat), .o_contact(cont));
  mto_monitor #(.P_TICK_CYCLES(TK)) mto_monitor_inst (
    .i_sys_clk(clk), .i_resetn(rstn), .i_addr(addr), .i_wr_data(wd), .i_wr_en(wen), .i_rd_en(ren),
    .o_rd_data(rdd), .i_output_current(cur), .i_in_term({th, cont}), .i_fault_reset(frst),
    .i_transistor_overload(tov), .o_out_term(ot), .o_prealarm_display(pre), .o_output_stop(stop),
    .o_motor_overload_trip(mtr), .o_external_relay_trip(ext), .o_transistor_overload_trip(ttr),
    .o_fault_code(fc), .o_second_set_active(sec), .o_irq(irq));
  // ==========================================================================
  // Tasks
  task automatic results();
    $display("Counts: %0d errors, %0d checked", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    wen  <= 1'b1;
    addr <= a;
    wd   <= d;
    @(posedge clk);
    wen <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    ren  <= 1'b1;
    addr <= a;
    @(posedge clk);
    ren <= 1'b0;
    #1;
    v = rdd;
  endtask
  task automatic clr();
    @(posedge clk);
    frst <= 1'b1;
    @(posedge clk);
    frst <= 1'b0;
    cyc(2);
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: return pre;
      1: return !pre;
      default: return mtr;
    endcase
  endfunction
  task automatic wait_on(input int w);
    int n;
    n = 0;
    while (sig(w) !== 1'b1 && n < 20000) begin
      cyc(1);
      n++;
    end
    if (n >= 20000) begin
      errors++;
      $display("Error at %0t: wait %0d timed out", $time, w);
      results();
    end
  endtask
  // Heat level reached at a percentage of a rated setting, unit 0.1 A.
  function automatic logic [31:0] hit(input logic [31:0] acc, input logic [31:0] r, input int p);
    return 32'((64'(acc) * 100) >= (64'(r) * 256 * p));
  endfunction
  // ==========================================================================
  // Main sequence
  initial begin
    seed = 32'hfb7ce2f0;
    {rstn, wen, ren, frst, tov, heat, addr, wd, cur, th} = '0;
    cyc(10);
    rstn <= 1'b1;
    cyc(1);
    chk({stop, mtr, ext, ttr, pre, irq, fc}, 32'h0);
    rd(OFS_RATED2);
    chk(v, 32'(RATED2_RST));
    rd(OFS_INSEL_LO);
    chk(v, 32'hffffffff);
    rd(8'hfc);
    chk(v, 32'h0);
    // Thermal disabled by rated1 zero; random current must not heat.
    cur <= 16'({$random(seed)} % 5000);
    cyc(40 * TK);
    rd(OFS_ACC1);
    chk(v, 32'h0);
    chk({mtr, pre}, 32'h0);
    @(posedge clk);
    tov <= 1'b1;
    @(posedge clk);
    tov <= 1'b0;
    cyc(20);
    chk({ttr, fc}, {23'h0, 1'b1, FAULT_THT});
    clr();
    chk(stop, 1'b0);
    // Steady heat between 85 and 100 percent of rated 1.0 A.
    wr(OFS_OUTSEL, 32'h00ff6c08);
    wr(OFS_IRQ_EN, 32'h5);
    wr(OFS_RATED1, 32'd10);
    cur <= 16'd9;
    cyc(8);
    chk(ot, 3'b010);
    wait_on(0);
    cyc(1);
    chk(ot, 3'b001);
    rd(OFS_ACC1);
    chk(hit(v, 10, 85), 1);
    chk(irq, 1'b1);
    cyc(3000);
    chk(stop, 1'b0);
    wr(OFS_IRQ_CLR, 32'h1);
    cyc(2);
    chk(irq, 1'b0);
    cur <= 16'd0;
    wait_on(1);
    cyc(1);
    chk(ot, 3'b010);
    cur <= 16'd20;
    wait_on(2);
    cyc(1);
    chk({stop, fc}, {23'h0, 1'b1, FAULT_THM});
    cur <= 16'd0;
    cyc(300);
    chk(mtr, 1'b1);
    clr();
    rd(OFS_ACC1);
    chk(32'(mtr), 32'h0);
    chk(v, 32'h0);
    // Second set select on terminal 1, relay on terminal 0.
    wr(OFS_INSEL_LO, 32'hffff0307);
    wr(OFS_RATED2, 32'd10);
    cur <= 16'd20;
    cyc(20 * TK);
    rd(OFS_ACC1);
    a1 = v;
    th[1] <= 1'b1;
    // Cooling must outrun the one heating tick that can land before the select settles.
    cyc(40 * TK);
    chk(sec, 1'b1);
    rd(OFS_ACC1);
    chk(32'(v < a1), 1);
    rd(OFS_ACC2);
    chk(32'(v != 0), 1);
    wr(OFS_RATED2, 32'(RATED_INVALID));
    cyc(2);
    rd(OFS_ACC2);
    chk(v, 32'h0);
    th[1] <= 1'b0;
    cur <= 16'd0;
    clr();
    // External relay only from a terminal coded 7.
    th[2] <= 1'b1;
    cyc(5);
    chk(ext, 1'b0);
    wr(OFS_IRQ_EN, 32'h4);
    heat <= 1'b1;
    cyc(3);
    chk({ext, stop, fc}, {22'h0, 2'b11, FAULT_OHT});
    chk(irq, 1'b1);
    wr(OFS_IRQ_EN, 32'h0);
    cyc(2);
    chk(irq, 1'b0);
    rd(OFS_STATUS);
    chk(v, {16'h0000, FAULT_OHT, 8'h14});
    rd(OFS_IRQ_STAT);
    chk(v, 32'h0000000f);
    wr(OFS_IRQ_CLR, 32'h0000000f);
    rd(OFS_IRQ_STAT);
    chk(v, 32'h0);
    heat <= 1'b0;
    results();
  end
endmodule

// ===== tb/mto_relay_model.sv
// Model of the outside overheat relay that drives one input terminal.
`timescale 1ns/1ps
module mto_relay_model (
  input  wire logic i_sys_clk,
  input  wire logic i_resetn,
  input  wire logic i_overheat,
  output logic      o_contact
);
  // ==========================================================================
  // Contact
  // The contact settles one cycle after the request, as a real relay lags.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_contact <= 1'b0;
    end else begin
      o_contact <= i_overheat;
    end
  end
endmodule
